// File: verilog/dmac_arbiter_ctrl.sv
// Reset handling, identity and per-master control registers of the two-master arbiter.
// Assumes register accesses arrive already decoded from each upstream serial port on clk;
// downstream SCL/SDA are open-drain pins from another clock domain.

`default_nettype none

module dmac_arbiter_ctrl #(
	parameter int IDLE_CYCLES = dmac_pkg::IDLE_CYCLES,
	parameter int SWRST_LOW_CYCLES = dmac_pkg::SWRST_LOW_CYCLES,
	parameter int SMBUS_TOUT_CYCLES = dmac_pkg::SMBUS_TOUT_CYCLES,
	parameter int INIT_HALF_CYCLES = dmac_pkg::INIT_HALF_CYCLES,
	parameter logic [7:0] ID_VALUE = dmac_pkg::ID_VALUE_DEF
) (
	input wire logic clk,
	input wire logic rst_n,
	input wire logic [1:0] reg_wr,
	input wire logic [2:0] reg_ptr_m0,
	input wire logic [2:0] reg_ptr_m1,
	input wire logic [7:0] reg_wdata_m0,
	input wire logic [7:0] reg_wdata_m1,
	output logic [7:0] reg_rdata_m0,
	output logic [7:0] reg_rdata_m1,
	input wire logic [1:0] gc_reset,
	input wire logic [1:0] reserve_done,
	input wire logic scl_in,
	input wire logic sda_in,
	output logic scl_o,
	output logic scl_oe,
	output logic sda_o,
	output logic sda_oe,
	output logic [1:0] connect,
	output logic [1:0] init_pass,
	output logic [1:0] init_fail
);
	import dmac_pkg::*;

	localparam int IW = $clog2(IDLE_CYCLES + 1);
	localparam int SW = $clog2(SWRST_LOW_CYCLES + 1);
	localparam int TW = $clog2(SMBUS_TOUT_CYCLES + 1);

	logic [7:0] ctrl [2];
	logic [2:0] ptr [2];
	logic [7:0] wdata [2];
	logic [7:0] rdata [2];
	logic [1:0] grant;
	logic [1:0] next_grant;
	logic [1:0] req;
	dmac_last_e last;
	logic sw_rst;
	logic sw_clk_low;
	logic [SW-1:0] hold_cnt;
	logic [SW-1:0] next_hold_cnt;
	logic hold_active;
	logic scl_meta;
	logic scl_s;
	logic sda_meta;
	logic sda_s;
	logic owner;
	logic [TW-1:0] tout_cnt;
	logic tout_hit;
	logic [IW-1:0] idle_cnt;
	logic idle_hit;
	logic [1:0] conn_req;
	logic [1:0] init_arm;
	logic init_start;
	logic init_sel;
	logic init_clear;
	logic init_scl;
	logic init_sda;
	logic init_busy;
	logic init_done;
	logic init_ok;

	assign ptr[0] = reg_ptr_m0;
	assign ptr[1] = reg_ptr_m1;
	assign wdata[0] = reg_wdata_m0;
	assign wdata[1] = reg_wdata_m1;
	assign reg_rdata_m0 = rdata[0];
	assign reg_rdata_m1 = rdata[1];

	// Downstream pins cross in through two flip-flops before anything looks at them
	always_ff @(posedge clk) begin
		scl_meta <= scl_in;
		scl_s <= scl_meta;
		sda_meta <= sda_in;
		sda_s <= sda_meta;
	end

	// Software reset; clock-low choice uses the sender's bit as it stood before the clear
	assign sw_rst = |gc_reset;
	assign sw_clk_low = (gc_reset[0] && ctrl[0][CTRL_SWRST_LOW]) ||
		(gc_reset[1] && ctrl[1][CTRL_SWRST_LOW]);

	// Clock-low hold timer after a software reset
	always_comb begin
		next_hold_cnt = hold_cnt;
		if (sw_clk_low) begin
			next_hold_cnt = SW'(SWRST_LOW_CYCLES);
		end else if (hold_cnt != '0) begin
			next_hold_cnt = hold_cnt - 1'b1;
		end
	end
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			hold_cnt <= '0;
		end else begin
			hold_cnt <= next_hold_cnt;
		end
	end
	assign hold_active = (hold_cnt != '0);

	// Per-master control registers and read-back
	generate
		for (genvar i = 0; i < 2; i++) begin : g_master
			always_ff @(posedge clk) begin
				if (!rst_n || sw_rst) begin
					ctrl[i] <= CTRL_RESET;
				end else begin
					if (reg_wr[i] && ptr[i] == PTR_CTRL) begin
						ctrl[i] <= wdata[i] & CTRL_WR_MASK;
					end
					// Hardware disconnects override a write in the same cycle
					if (tout_hit && grant[i]) begin
						ctrl[i][CTRL_BUS_CONNECT] <= 1'b0;
					end
					if (idle_hit && grant[i]) begin
						ctrl[i][CTRL_BUS_CONNECT] <= 1'b0;
						ctrl[i][CTRL_LOCK_REQ] <= 1'b0;
					end
					if (init_done && init_sel == 1'(i)) begin
						ctrl[i][CTRL_BUS_INIT] <= 1'b0;
					end
				end
			end

			// Grant bit is live state, not stored; unmapped pointers read zero
			always_ff @(posedge clk) begin
				if (!rst_n) begin
					rdata[i] <= 8'h00;
				end else if (ptr[i] == PTR_ID) begin
					rdata[i] <= ID_VALUE;
				end else if (ptr[i] == PTR_CTRL) begin
					rdata[i] <= {ctrl[i][7:2], grant[i], ctrl[i][CTRL_LOCK_REQ]};
				end else begin
					rdata[i] <= 8'h00;
				end
			end

			assign req[i] = ctrl[i][CTRL_LOCK_REQ];
			assign conn_req[i] = grant[i] && ctrl[i][CTRL_BUS_CONNECT] && !hold_active;
			assign init_arm[i] = conn_req[i] && !connect[i] && ctrl[i][CTRL_BUS_INIT];
		end
	endgenerate

	// Arbitration; a held grant is kept until the owner drops its request
	always_comb begin
		next_grant = grant;
		if (grant == 2'b00) begin
			if (req == 2'b11) begin
				if (ctrl[0][CTRL_PRIORITY] != ctrl[1][CTRL_PRIORITY]) begin
					next_grant = ctrl[1][CTRL_PRIORITY] ? 2'b10 : 2'b01;
				end else if (last == LAST_NONE) begin
					next_grant = ctrl[0][CTRL_PRIORITY] ? 2'b10 : 2'b01;
				end else begin
					next_grant = (last == LAST_M0) ? 2'b10 : 2'b01;
				end
			end else begin
				next_grant = req;
			end
		end else if (!req[owner]) begin
			next_grant = 2'b00;
		end
	end
	assign owner = grant[1];

	always_ff @(posedge clk) begin
		if (!rst_n || sw_rst) begin
			grant <= 2'b00;
			last <= LAST_NONE;
		end else begin
			grant <= next_grant;
			if (next_grant == 2'b01) begin
				last <= LAST_M0;
			end else if (next_grant == 2'b10) begin
				last <= LAST_M1;
			end
		end
	end

	// SMBus time-out: SCL held low on the connected bus for the time-out period
	always_ff @(posedge clk) begin
		if (!rst_n || sw_rst || scl_s || connect == 2'b00) begin
			tout_cnt <= '0;
		end else if (tout_cnt != TW'(SMBUS_TOUT_CYCLES)) begin
			tout_cnt <= tout_cnt + 1'b1;
		end
	end
	assign tout_hit = (tout_cnt == TW'(SMBUS_TOUT_CYCLES)) && ctrl[owner][CTRL_TOUT_DIS];

	// Idle timer runs only once reserve time is over (or was zero at grant)
	always_ff @(posedge clk) begin
		if (!rst_n || sw_rst || grant == 2'b00 || !reserve_done[owner] ||
			!ctrl[owner][CTRL_IDLE_EN] || !scl_s || !sda_s) begin
			idle_cnt <= '0;
		end else if (idle_cnt != IW'(IDLE_CYCLES)) begin
			idle_cnt <= idle_cnt + 1'b1;
		end
	end
	assign idle_hit = (idle_cnt == IW'(IDLE_CYCLES));

	// Armed initialization fires on a fresh connection, switch kept open meanwhile
	assign init_start = (|init_arm) && !init_busy;
	assign init_clear = !rst_n || sw_rst;
	always_ff @(posedge clk) begin
		if (init_clear) begin
			init_sel <= 1'b0;
		end else if (init_start) begin
			init_sel <= init_arm[1] && !init_arm[0];
		end
	end

	dmac_bus_init #(
		.HALF_CYCLES(INIT_HALF_CYCLES),
		.MAX_CLOCKS(INIT_MAX_CLOCKS)
	) u_bus_init (
		.clk(clk),
		.clear(init_clear),
		.start(init_start),
		.sda_s(sda_s),
		.scl_drive(init_scl),
		.sda_drive(init_sda),
		.busy(init_busy),
		.done(init_done),
		.pass(init_ok)
	);

	// Result kept per master until that master's next initialization ends
	always_ff @(posedge clk) begin
		if (!rst_n || sw_rst) begin
			init_pass <= 2'b00;
			init_fail <= 2'b00;
		end else if (init_done) begin
			init_pass[init_sel] <= init_ok;
			init_fail[init_sel] <= !init_ok;
		end
	end

	// Switch and open-drain drivers; pins only ever pull low
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			connect <= 2'b00;
			scl_oe <= 1'b0;
			sda_oe <= 1'b0;
		end else begin
			connect <= init_busy || init_start ? 2'b00 : conn_req;
			scl_oe <= (next_hold_cnt != '0) || init_scl;
			sda_oe <= init_sda;
		end
	end
	assign scl_o = 1'b0;
	assign sda_o = 1'b0;

	default clocking arb_cb @(posedge clk);
	endclocking
	default disable iff (!rst_n);

	sequence swrst_low_s;
		sw_clk_low ##1 scl_oe [*8];
	endsequence
	sequence swrst_quiet_s;
		sw_rst && !sw_clk_low && !hold_active && !init_busy;
	endsequence

	reset_defaults_a: assert property (disable iff (1'b0) !rst_n |=>
		ctrl[0] == CTRL_RESET && ctrl[1] == CTRL_RESET && grant == 2'b00)
		else $error("registers not at defaults during reset");
	release_open_a: assert property ($rose(rst_n) |-> connect == 2'b00 ##1 connect == 2'b00)
		else $error("bus connected right after reset release");
	swrst_clear_a: assert property (sw_rst |=> ctrl[0] == CTRL_RESET && ctrl[1] == CTRL_RESET)
		else $error("software reset left a register set");
	swrst_hold_a: assert property (sw_clk_low |-> swrst_low_s)
		else $error("SCL not held low after software reset");
	swrst_quiet_a: assert property (swrst_quiet_s |=> !sw_clk_low |=> !scl_oe)
		else $error("SCL pulled low without clock-low enable");
	id_read_a: assert property (reg_ptr_m1 == PTR_ID |=> reg_rdata_m1 == ID_VALUE)
		else $error("identity read returned wrong code");
	ctrl_split_a: assert property (reg_wr == 2'b01 && reg_ptr_m0 == PTR_CTRL && !sw_rst |=>
		ctrl[0][7:4] == $past(reg_wdata_m0[7:4]) && $stable(ctrl[1][7:4]))
		else $error("control write reached the wrong master");
	priority_win_a: assert property (grant == 2'b00 && req == 2'b11 && !sw_rst &&
		ctrl[0][CTRL_PRIORITY] != ctrl[1][CTRL_PRIORITY] |=> grant[1] == $past(ctrl[1][7]))
		else $error("priority master did not win");
	alternate_win_a: assert property (grant == 2'b00 && req == 2'b11 && !sw_rst &&
		ctrl[0][CTRL_PRIORITY] == ctrl[1][CTRL_PRIORITY] && last == LAST_M0 |=> grant == 2'b10)
		else $error("equal priority did not alternate");
	tout_drop_a: assert property (tout_hit && !sw_rst |-> ##2 connect == 2'b00)
		else $error("time-out did not disconnect");
	idle_drop_a: assert property (idle_hit && !sw_rst |-> ##2 grant == 2'b00)
		else $error("idle timer did not withdraw grant");

endmodule : dmac_arbiter_ctrl

`default_nettype wire

// File: verilog/dmac_pkg.sv
// Constants, encodings and timing figures for the dual master arbiter control block.
// Assumes a single 10 MHz system clock; all times below are converted against it.

`default_nettype none

package dmac_pkg;

	// Clock and times in their own units
	localparam int CLK_HZ = 10_000_000;
	localparam int SWRST_LOW_MS = 35;
	localparam int IDLE_MS = 100;
	localparam int SMBUS_TOUT_MS = 25;
	localparam int INIT_SCL_HZ = 100_000;

	// Derived cycle counts; "more than" figures get one extra cycle
	localparam int SWRST_LOW_CYCLES = (CLK_HZ / 1000) * SWRST_LOW_MS + 1;
	localparam int IDLE_CYCLES = (CLK_HZ / 1000) * IDLE_MS;
	localparam int SMBUS_TOUT_CYCLES = (CLK_HZ / 1000) * SMBUS_TOUT_MS;
	localparam int INIT_HALF_CYCLES = CLK_HZ / (2 * INIT_SCL_HZ);
	localparam int INIT_MAX_CLOCKS = 9;

	// Register pointers
	localparam logic [2:0] PTR_ID = 3'h0;
	localparam logic [2:0] PTR_CTRL = 3'h1;

	// Identity code: value is arbitrary, chosen only to be recognisable
	localparam logic [7:0] ID_VALUE_DEF = 8'h5a;

	// Control register layout and reset value
	localparam int CTRL_PRIORITY = 7;
	localparam int CTRL_TOUT_DIS = 6;
	localparam int CTRL_IDLE_EN = 5;
	localparam int CTRL_SWRST_LOW = 4;
	localparam int CTRL_BUS_INIT = 3;
	localparam int CTRL_BUS_CONNECT = 2;
	localparam int CTRL_LOCK_GRANT = 1;
	localparam int CTRL_LOCK_REQ = 0;
	localparam logic [7:0] CTRL_RESET = 8'h00;
	localparam logic [7:0] CTRL_WR_MASK = 8'hfd;

	// Which master held the bus last
	typedef enum logic [1:0] {
		LAST_NONE = 2'b00,
		LAST_M0 = 2'b01,
		LAST_M1 = 2'b11
	} dmac_last_e;

	// Bus initialization sequencer, Gray along the clock loop
	typedef enum logic [2:0] {
		INIT_IDLE = 3'b000,
		INIT_CLK_LO = 3'b001,
		INIT_CLK_HI = 3'b011,
		INIT_NACK_LO = 3'b010,
		INIT_NACK_HI = 3'b110,
		INIT_STOP_LO = 3'b111,
		INIT_STOP_HI = 3'b101
	} dmac_init_e;

endpackage : dmac_pkg

`default_nettype wire

// File: verilog/dmac_bus_init.sv
// Downstream bus initialization sequencer: clocks SCL until SDA is released, at most MAX_CLOCKS times.
// Assumes sda_s is already synchronised and that the switch is open while busy.

`default_nettype none

module dmac_bus_init #(
	parameter int HALF_CYCLES = dmac_pkg::INIT_HALF_CYCLES,
	parameter int MAX_CLOCKS = dmac_pkg::INIT_MAX_CLOCKS
) (
	input wire logic clk,
	input wire logic clear,
	input wire logic start,
	input wire logic sda_s,
	output logic scl_drive,
	output logic sda_drive,
	output logic busy,
	output logic done,
	output logic pass
);
	import dmac_pkg::*;

	localparam int HW = $clog2(HALF_CYCLES + 1);
	localparam int CW = $clog2(MAX_CLOCKS + 1);

	dmac_init_e state;
	logic [HW-1:0] half_cnt;
	logic [CW-1:0] clocks;
	logic tick;

	// Half-period divider, held at zero between sequences
	assign tick = (half_cnt == HW'(HALF_CYCLES - 1));
	always_ff @(posedge clk) begin
		if (clear || state == INIT_IDLE || tick) begin
			half_cnt <= '0;
		end else begin
			half_cnt <= half_cnt + 1'b1;
		end
	end

	// Sequence: clock and sample, then NACK clock and STOP
	always_ff @(posedge clk) begin
		done <= 1'b0;
		if (clear) begin
			state <= INIT_IDLE;
			clocks <= '0;
			pass <= 1'b0;
		end else begin
			case (state)
				INIT_IDLE: begin
					clocks <= '0;
					if (start) begin
						state <= INIT_CLK_LO;
					end
				end
				INIT_CLK_LO: if (tick) begin
					state <= INIT_CLK_HI;
				end
				INIT_CLK_HI: if (tick) begin
					clocks <= clocks + 1'b1;
					if (sda_s) begin
						state <= INIT_NACK_LO;
					end else if (clocks == CW'(MAX_CLOCKS - 1)) begin
						state <= INIT_IDLE;
						done <= 1'b1;
						pass <= 1'b0;
					end else begin
						state <= INIT_CLK_LO;
					end
				end
				INIT_NACK_LO: if (tick) begin
					state <= INIT_NACK_HI;
				end
				INIT_NACK_HI: if (tick) begin
					state <= INIT_STOP_LO;
				end
				INIT_STOP_LO: if (tick) begin
					state <= INIT_STOP_HI;
				end
				INIT_STOP_HI: if (tick) begin
					state <= INIT_IDLE;
					done <= 1'b1;
					pass <= 1'b1;
				end
				default: state <= INIT_IDLE;
			endcase
		end
	end

	// SDA released during NACK; low then released again forms the STOP
	assign busy = (state != INIT_IDLE);
	assign scl_drive = (state == INIT_CLK_LO) || (state == INIT_NACK_LO) || (state == INIT_STOP_LO);
	assign sda_drive = (state == INIT_STOP_LO) || (state == INIT_STOP_HI);

	default clocking init_cb @(posedge clk);
	endclocking
	default disable iff (clear);

	init_limit_a: assert property (clocks <= CW'(MAX_CLOCKS))
		else $error("initialization sent more clocks than allowed");
	init_release_a: assert property (state == INIT_CLK_HI && tick && sda_s |=>
		state == INIT_NACK_LO ##1 (!sda_drive) [*2])
		else $error("released SDA did not lead to NACK");

endmodule : dmac_bus_init

`default_nettype wire

// File: verif/dmac_bus_model.sv
// Downstream bus partner: a slave that may hold SDA low for some clocks,
// stretch SCL, or run bursts of clock traffic. Lines have pull-ups.
`default_nettype none

module dmac_bus_model (
	input wire logic scl,
	input wire logic load,
	input wire logic [4:0] hold_clocks,
	input wire logic stretch,
	input wire logic run,
	output logic scl_low,
	output logic sda_low
);
	timeunit 1ns;
	timeprecision 100ps;
	int cnt = 0;
	logic tgl = 1'b0;

	// Clock edges seen since the last load decide when SDA lets go
	always @(posedge load) cnt = 0;
	always @(posedge scl) cnt = cnt + 1;
	assign sda_low = (cnt < int'(hold_clocks));

	// Traffic clock of 800 ns period, standing still outside bursts
	always begin
		#400;
		tgl = run ? !tgl : 1'b0;
	end
	assign scl_low = stretch | tgl;
endmodule : dmac_bus_model

`default_nettype wire

// File: verif/dmac_arbiter_ctrl_tb.sv
// Bench for the arbiter control block: register tasks, arbitration,
// resets, idle and time-out disconnects and bus initialization.
// Assumes the partner model above sits on the open-drain downstream pins.
`default_nettype none

module dmac_arbiter_ctrl_tb;
	timeunit 1ns;
	timeprecision 100ps;
	import dmac_pkg::*;
	localparam int IDLE = 200;
	localparam int SWLOW = 50;
	localparam int TOUT = 100;
	logic clk = 1'b0;
	logic rst_n = 1'b0;
	logic [1:0] reg_wr = '0, gc_reset = '0, reserve_done = '0;
	logic [2:0] ptr_m0 = 3'h1, ptr_m1 = 3'h1;
	logic [7:0] wd_m0 = '0, wd_m1 = '0, rd_m0, rd_m1;
	logic scl_in, sda_in, scl_o, scl_oe, sda_o, sda_oe;
	logic [1:0] connect, init_pass, init_fail;
	logic load = 1'b0, stretch = 1'b0, run = 1'b0, scl_low, sda_low, prev = 1'b0;
	logic sda_prev = 1'b0;
	logic [4:0] hold = '0;
	int err_count = 0, tests_run = 0, pulses = 0, n;
	int sda_pulls = 0;

	always #50 clk = !clk;
	// Open-drain wires with pull-ups
	assign scl_in = !(scl_oe | scl_low);
	assign sda_in = !(sda_oe | sda_low);
	// Count SCL pulls made by the block
	always @(posedge clk) begin
		if (scl_oe && !prev) pulses = pulses + 1;
		prev = scl_oe;
		// SDA pulls by the block: only the STOP of a passing initialization makes one
		if (sda_oe && !sda_prev) sda_pulls = sda_pulls + 1;
		sda_prev = sda_oe;
	end

	dmac_arbiter_ctrl #(.IDLE_CYCLES(IDLE), .SWRST_LOW_CYCLES(SWLOW),
		.SMBUS_TOUT_CYCLES(TOUT), .INIT_HALF_CYCLES(8)) uut (
		.clk(clk), .rst_n(rst_n), .reg_wr(reg_wr), .reg_ptr_m0(ptr_m0),
		.reg_ptr_m1(ptr_m1), .reg_wdata_m0(wd_m0), .reg_wdata_m1(wd_m1),
		.reg_rdata_m0(rd_m0), .reg_rdata_m1(rd_m1), .gc_reset(gc_reset),
		.reserve_done(reserve_done), .scl_in(scl_in), .sda_in(sda_in),
		.scl_o(scl_o), .scl_oe(scl_oe), .sda_o(sda_o), .sda_oe(sda_oe),
		.connect(connect), .init_pass(init_pass), .init_fail(init_fail));

	dmac_bus_model bus (.scl(scl_in), .load(load), .hold_clocks(hold),
		.stretch(stretch), .run(run), .scl_low(scl_low), .sda_low(sda_low));

	task end_of_test;
		$display("comparisons %0d mismatches %0d", tests_run, err_count);
		if (err_count == 0 && tests_run > 0) $display("bench passed");
		else $display("bench failed");
		$finish;
	endtask : end_of_test

	task tick;
		@(posedge clk);
		#1;
	endtask : tick

	task chk(input logic [7:0] seen, input logic [7:0] exp);
		tests_run++;
		if (seen !== exp) begin
			err_count++;
			$display("BAD %0t seen %h expected %h", $time, seen, exp);
		end
	endtask : chk

	// A wait that ran out of its bound ends the run
	task to(input logic ok);
		chk(8'(ok), 8'h01);
		if (ok !== 1'b1) end_of_test();
	endtask : to

	task wr(input int m, input logic [2:0] p, input logic [7:0] v);
		if (m == 0) begin
			ptr_m0 = p;
			wd_m0 = v;
		end else begin
			ptr_m1 = p;
			wd_m1 = v;
		end
		reg_wr[m] = 1'b1;
		tick();
		reg_wr = 2'b00;
		tick();
	endtask : wr

	task wr2(input logic [7:0] v0, input logic [7:0] v1);
		ptr_m0 = 3'h1;
		ptr_m1 = 3'h1;
		wd_m0 = v0;
		wd_m1 = v1;
		reg_wr = 2'b11;
		tick();
		reg_wr = 2'b00;
		tick();
	endtask : wr2

	// Read data is registered, so allow the pointer two edges
	task cr(input int m, input logic [2:0] p, input logic [7:0] exp);
		if (m == 0) ptr_m0 = p;
		else ptr_m1 = p;
		tick();
		tick();
		chk(m ? rd_m1 : rd_m0, exp);
	endtask : cr

	task gc(input logic [1:0] who);
		gc_reset = who;
		tick();
		gc_reset = 2'b00;
	endtask : gc

	// Both request in one cycle; winner w shows the grant bit
	task arb(input logic p0, input logic p1, input int w);
		wr2({p0, 7'h01}, {p1, 7'h01});
		repeat (4) tick();
		cr(0, 3'h1, {p0, 5'h00, w == 0, 1'b1});
		cr(1, 3'h1, {p1, 5'h00, w == 1, 1'b1});
		wr2(8'h00, 8'h00);
		repeat (3) tick();
	endtask : arb

	initial begin
		repeat (8) tick();
		rst_n = 1'b1;
		tick();
		chk(8'(connect), 8'h00);
		cr(0, 3'h0, ID_VALUE_DEF);
		cr(1, 3'h0, ID_VALUE_DEF);
		cr(1, 3'h1, CTRL_RESET);
		cr(0, 3'h1, CTRL_RESET);
		wr(0, 3'h0, 8'h11);
		cr(0, 3'h0, ID_VALUE_DEF);
		cr(0, 3'h2, 8'h00);
		wr(0, 3'h1, 8'h80);
		wr(1, 3'h1, 8'h40);
		cr(0, 3'h1, 8'h80);
		cr(1, 3'h1, 8'h40);
		wr2(8'h00, 8'h00);
		$display("test registers done");

		arb(1'b0, 1'b0, 0);
		arb(1'b0, 1'b0, 1);
		arb(1'b0, 1'b0, 0);
		arb(1'b0, 1'b1, 1);
		arb(1'b1, 1'b0, 0);
		// Non-granted master resets with clock-low off
		wr(1, 3'h1, 8'h80);
		wr(0, 3'h1, 8'h01);
		pulses = 0;
		gc(2'b10);
		repeat (60) tick();
		chk(8'(pulses), 8'h00);
		cr(0, 3'h1, 8'h00);
		cr(1, 3'h1, 8'h00);
		arb(1'b1, 1'b1, 1);
		arb(1'b1, 1'b1, 0);
		arb(1'b1, 1'b1, 1);
		$display("test arbitration done");

		wr(1, 3'h1, 8'h10);
		gc(2'b10);
		for (n = 0; n < 3 && scl_oe !== 1'b1; n++) tick();
		to(scl_oe);
		chk(8'({scl_o, scl_oe}), 8'h01);
		for (n = 0; n < 200 && scl_oe === 1'b1; n++) tick();
		chk(8'(n), 8'(SWLOW));
		cr(1, 3'h1, 8'h00);
		$display("test clock low done");

		wr(0, 3'h1, 8'h25);
		for (n = 0; n < 20 && connect[0] !== 1'b1; n++) tick();
		to(connect[0]);
		repeat (IDLE + 50) tick();
		chk(8'(connect), 8'h01);
		reserve_done = 2'b01;
		run = 1'b1;
		repeat (300) tick();
		chk(8'(connect), 8'h01);
		run = 1'b0;
		for (n = 0; n < IDLE + 30 && connect[0] !== 1'b0; n++) tick();
		to(!connect[0]);
		chk(8'(n > IDLE - 10), 8'h01);
		cr(0, 3'h1, 8'h20);
		wr(0, 3'h1, 8'h25);
		// The switch closes one edge after the write task returns
		for (n = 0; n < 20 && connect[0] !== 1'b1; n++) tick();
		to(connect[0]);
		for (n = 0; n < IDLE + 40 && connect[0] !== 1'b0; n++) tick();
		to(!connect[0]);
		chk(8'(n > IDLE - 10), 8'h01);
		wr(0, 3'h1, 8'h00);
		reserve_done = 2'b00;
		$display("test idle done");

		wr(1, 3'h1, 8'h05);
		repeat (5) tick();
		stretch = 1'b1;
		repeat (2 * TOUT) tick();
		chk(8'(connect), 8'h02);
		stretch = 1'b0;
		// Let the synchronised SCL clear the saturated time-out count first
		repeat (4) tick();
		wr(1, 3'h1, 8'h45);
		stretch = 1'b1;
		for (n = 0; n < TOUT + 20 && connect[1] !== 1'b0; n++) tick();
		to(!connect[1]);
		chk(8'(n > TOUT - 10), 8'h01);
		stretch = 1'b0;
		cr(1, 3'h1, 8'h43);
		wr(1, 3'h1, 8'h00);
		$display("test time-out done");

		pulses = 0;
		sda_pulls = 0;
		hold = 5'd3;
		load = 1'b1;
		wr(0, 3'h1, 8'h08);
		repeat (60) tick();
		chk(8'(pulses), 8'h00);
		wr(0, 3'h1, 8'h0d);
		for (n = 0; n < 3000 && init_pass[0] !== 1'b1; n++) tick();
		to(init_pass[0]);
		chk(8'(init_fail), 8'h00);
		chk(8'(pulses > 3), 8'h01);
		chk(8'(sda_pulls), 8'h01);
		chk(8'(sda_o), 8'h00);
		for (n = 0; n < 50 && connect[0] !== 1'b1; n++) tick();
		to(connect[0]);
		cr(0, 3'h1, 8'h07);
		wr(0, 3'h1, 8'h00);
		load = 1'b0;
		hold = 5'd31;
		pulses = 0;
		sda_pulls = 0;
		tick();
		load = 1'b1;
		wr(0, 3'h1, 8'h0d);
		for (n = 0; n < 3000 && init_fail[0] !== 1'b1; n++) tick();
		to(init_fail[0]);
		chk(8'(pulses), 8'd9);
		chk(8'(sda_pulls), 8'h00);
		chk(8'(init_pass), 8'h00);
		wr(0, 3'h1, 8'h00);
		hold = 5'd0;
		$display("test bus init done");

		wr(0, 3'h1, 8'h05);
		repeat (5) tick();
		rst_n = 1'b0;
		repeat (2) tick();
		chk(8'(connect), 8'h00);
		rst_n = 1'b1;
		tick();
		chk(8'(connect), 8'h00);
		cr(0, 3'h1, 8'h00);
		$display("test second reset done");
		end_of_test();
	end
endmodule : dmac_arbiter_ctrl_tb

`default_nettype wire
